// ### rtl/flash_host_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter logic [21:0] UNLOCK_ADDR_A = 22'h000555,
    parameter logic [21:0] UNLOCK_ADDR_B = 22'h0002AA,
    parameter logic [15:0] UNLOCK_DATA_A = 16'h00AA,
    parameter logic [15:0] UNLOCK_DATA_B = 16'h0055,
    parameter logic [15:0] PROGRAM_CMD = 16'h00A0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // User command port
    input wire logic cmdValid,
    input wire logic [1:0] cmdOp,
    input wire logic [22:0] cmdAddr,
    input wire logic [15:0] cmdData,
    input wire logic byteMode,
    input wire logic fastMode,
    input wire logic accelReq,
    output logic cmdReady,
    output logic rdValid,
    output logic [15:0] rdData,
    output logic opAborted,
    output logic deviceBusy,
    // Flash pins
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic flashResetN,
    output logic flashByteN,
    output logic [21:0] flashAddr,
    output logic [15:0] dqOut,
    output logic [15:0] dqOe,
    input wire logic [15:0] dqIn,
    input wire logic busy_output_n,
    output logic protect_accel_pin,
    output logic high_program_voltage
);
    // ==========================================================
    // State
    typedef enum logic [2:0] {S_IDLE, S_RD, S_WR_LOW, S_WR_HIGH, S_CLR} state_e;

    state_e state_reg;
    logic [7:0] cnt_reg;
    logic [7:0] holdoff_reg;
    logic [1:0] step_reg;
    logic [22:0] addr_reg;
    logic [15:0] data_reg;
    logic hv_reg;
    logic ceN_reg, oeN_reg, weN_reg, resetN_reg, byteN_reg;
    logic [21:0] pinAddr_reg;
    logic [15:0] dqOut_reg, dqOe_reg, rdData_reg;
    logic rdValid_reg, aborted_reg;

    function automatic logic [21:0] step_addr(input logic [1:0] s, input logic [22:0] a);
        case (s)
            2'h0: step_addr = UNLOCK_ADDR_A;
            2'h1: step_addr = UNLOCK_ADDR_B;
            2'h2: step_addr = UNLOCK_ADDR_A;
            default: step_addr = a[22:1];
        endcase
    endfunction : step_addr

    function automatic logic [15:0] step_data(input logic [1:0] s, input logic [15:0] d);
        case (s)
            2'h0: step_data = UNLOCK_DATA_A;
            2'h1: step_data = UNLOCK_DATA_B;
            2'h2: step_data = PROGRAM_CMD;
            default: step_data = d;
        endcase
    endfunction : step_data

    // ==========================================================
    // Decode
    wire logic isRead = (cmdOp == OP_READ);
    wire logic cmdAccept = cmdValid && cmdReady;
    // Reads wait out the post-clear delay; writes and clears do not
    assign cmdReady = (state_reg == S_IDLE) && (!isRead || holdoff_reg == 8'h00);
    wire logic fastSeq = fastMode || accelReq;
    wire logic [1:0] firstStep = (cmdOp == OP_PROGRAM) ? (fastSeq ? STEP_FAST : STEP_FIRST)
                                                       : STEP_DATA;
    wire logic cntDone = (cnt_reg == 8'h00);
    wire logic [7:0] cntDec = cnt_reg - 8'h01;
    wire logic [1:0] stepNext = step_reg + 2'h1;
    // In byte width line 15 carries the lowest address bit
    wire logic [15:0] stepWord = step_data(step_reg, data_reg);
    wire logic [15:0] wrBus = !byteN_reg ? {addr_reg[0], 7'h00, stepWord[7:0]}
                                         : stepWord;
    wire logic [15:0] wrOe = !byteN_reg ? DQ_BYTE_WR : DQ_ALL;
    wire logic [15:0] rdBus = byteMode ? {cmdAddr[0], 15'h0000} : DQ_NONE;
    wire logic [15:0] rdOe = byteMode ? DQ_BYTE_RD : DQ_NONE;
    wire logic [15:0] rdWord = byteN_reg ? dqIn : {8'h00, dqIn[7:0]};

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= S_IDLE;
            cnt_reg <= 8'h00;
            holdoff_reg <= 8'h00;
            step_reg <= STEP_FIRST;
            addr_reg <= 23'h000000;
            data_reg <= 16'h0000;
            hv_reg <= 1'b0;
            ceN_reg <= 1'b1;
            oeN_reg <= 1'b1;
            weN_reg <= 1'b1;
            resetN_reg <= 1'b1;
            byteN_reg <= 1'b1;
            pinAddr_reg <= 22'h000000;
            dqOut_reg <= 16'h0000;
            dqOe_reg <= DQ_NONE;
            rdData_reg <= 16'h0000;
            rdValid_reg <= 1'b0;
            aborted_reg <= 1'b0;
        end else begin
            rdValid_reg <= 1'b0;
            if (holdoff_reg != 8'h00) begin
                holdoff_reg <= holdoff_reg - 8'h01;
            end
            // High voltage only while an accelerated program is wanted
            if (!accelReq) begin
                hv_reg <= 1'b0;
            end
            case (state_reg)
                S_IDLE: begin
                    if (cmdAccept) begin
                        addr_reg <= cmdAddr;
                        data_reg <= cmdData;
                        byteN_reg <= !byteMode;
                        step_reg <= firstStep;
                        hv_reg <= accelReq && (cmdOp == OP_PROGRAM);
                        aborted_reg <= 1'b0;
                        case (cmdOp)
                            OP_READ: begin
                                // Full access delay every time covers standby exit
                                ceN_reg <= 1'b0;
                                oeN_reg <= 1'b0;
                                pinAddr_reg <= cmdAddr[22:1];
                                dqOut_reg <= rdBus;
                                dqOe_reg <= rdOe;
                                cnt_reg <= 8'(ACCESS_CYC);
                                state_reg <= S_RD;
                            end
                            OP_CLEAR: begin
                                resetN_reg <= 1'b0;
                                ceN_reg <= 1'b1;
                                oeN_reg <= 1'b1;
                                dqOe_reg <= DQ_NONE;
                                aborted_reg <= !busy_output_n || hv_reg;
                                cnt_reg <= 8'(CLEAR_CYC - 1);
                                state_reg <= S_CLR;
                            end
                            default: begin
                                cnt_reg <= 8'(WE_LOW_CYC);
                                state_reg <= S_WR_HIGH;
                            end
                        endcase
                    end
                end
                S_RD: begin
                    if (cntDone) begin
                        rdData_reg <= rdWord;
                        rdValid_reg <= 1'b1;
                        ceN_reg <= 1'b1;
                        oeN_reg <= 1'b1;
                        dqOe_reg <= DQ_NONE;
                        state_reg <= S_IDLE;
                    end else begin
                        cnt_reg <= cntDec;
                    end
                end
                S_WR_HIGH: begin
                    // Setup gap before each strobe, output enable kept high
                    if (cntDone) begin
                        oeN_reg <= 1'b1;
                        ceN_reg <= 1'b0;
                        weN_reg <= 1'b0;
                        pinAddr_reg <= step_addr(step_reg, addr_reg);
                        dqOut_reg <= wrBus;
                        dqOe_reg <= wrOe;
                        cnt_reg <= 8'(WE_LOW_CYC - 1);
                        state_reg <= S_WR_LOW;
                    end else begin
                        cnt_reg <= cntDec;
                    end
                end
                S_WR_LOW: begin
                    if (cntDone) begin
                        weN_reg <= 1'b1;
                        ceN_reg <= 1'b1;
                        cnt_reg <= 8'(WE_HIGH_CYC);
                        if (step_reg == STEP_DATA) begin
                            state_reg <= S_IDLE;
                        end else begin
                            step_reg <= stepNext;
                            state_reg <= S_WR_HIGH;
                        end
                    end else begin
                        cnt_reg <= cntDec;
                    end
                end
                S_CLR: begin
                    if (cntDone) begin
                        resetN_reg <= 1'b1;
                        holdoff_reg <= 8'(POST_CLEAR_CYC);
                        state_reg <= S_IDLE;
                    end else begin
                        cnt_reg <= cntDec;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Outputs
    assign flashCeN = ceN_reg;
    assign flashOeN = oeN_reg;
    assign flashWeN = weN_reg;
    assign flashResetN = resetN_reg;
    assign flashByteN = byteN_reg;
    assign flashAddr = pinAddr_reg;
    assign dqOut = dqOut_reg;
    // Data lines stay driven after a write until the next read or clear resets the enables
    assign dqOe = dqOe_reg;
    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign opAborted = aborted_reg;
    assign deviceBusy = !busy_output_n;
    // Pin always driven high when not accelerating, never floating
    assign protect_accel_pin = 1'b1;
    assign high_program_voltage = hv_reg;

    // ==========================================================
    // Assertions
    property p_cmd_levels;
        @(posedge clk) disable iff (!nrst) !flashWeN |-> (!flashCeN && flashOeN);
    endproperty
    a_cmd_levels: assert property (p_cmd_levels) else $error("write strobe without select");

    property p_fast_start;
        @(posedge clk) disable iff (!nrst)
            (cmdAccept && cmdOp == OP_PROGRAM && fastSeq) |=> (step_reg == STEP_FAST);
    endproperty
    a_fast_start: assert property (p_fast_start) else $error("fast program not two cycles");

    property p_norm_start;
        @(posedge clk) disable iff (!nrst)
            (cmdAccept && cmdOp == OP_PROGRAM && !fastSeq) |=> (step_reg == STEP_FIRST);
    endproperty
    a_norm_start: assert property (p_norm_start) else $error("normal program not four cycles");

    property p_hv_cause;
        @(posedge clk) disable iff (!nrst)
            $rose(high_program_voltage) |-> $past(cmdAccept && cmdOp == OP_PROGRAM && accelReq);
    endproperty
    a_hv_cause: assert property (p_hv_cause) else $error("high voltage outside program");

    property p_hv_noread;
        @(posedge clk) disable iff (!nrst) high_program_voltage |-> flashOeN;
    endproperty
    a_hv_noread: assert property (p_hv_noread) else $error("read under high voltage");

    property p_clear_width;
        @(posedge clk) disable iff (!nrst) $fell(flashResetN) |-> !flashResetN [*5];
    endproperty
    a_clear_width: assert property (p_clear_width) else $error("clear pulse too short");

    property p_post_clear;
        @(posedge clk) disable iff (!nrst) $rose(flashResetN) |-> flashOeN [*2];
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("read too soon after clear");

    property p_abort_flag;
        @(posedge clk) disable iff (!nrst)
            (cmdAccept && cmdOp == OP_CLEAR && !busy_output_n) |=> opAborted;
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("abort not reported");

    property p_byte_lines;
        @(posedge clk) disable iff (!nrst)
            (!flashByteN && !(flashOeN && flashWeN)) |-> (dqOe[15] && dqOe[14:8] == 7'h00);
    endproperty
    a_byte_lines: assert property (p_byte_lines) else $error("byte width line misuse");

    c_read: cover property (@(posedge clk) disable iff (!nrst) rdValid);
    c_fast: cover property (@(posedge clk) disable iff (!nrst)
        cmdAccept && cmdOp == OP_PROGRAM && accelReq);
    c_clear: cover property (@(posedge clk) disable iff (!nrst) $rose(flashResetN));
endmodule : flash_host_ctrl
`default_nettype wire

// ### shared/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 10;
    localparam int ACCESS_NS = 70;
    localparam int WE_LOW_NS = 35;
    localparam int WE_HIGH_NS = 25;
    localparam int CLEAR_PULSE_NS = 500;
    localparam int POST_CLEAR_NS = 50;
    // Least times, rounded up to whole cycles
    localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_HIGH_CYC = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int CLEAR_CYC = (CLEAR_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int POST_CLEAR_CYC = (POST_CLEAR_NS * CLK_MHZ + 999) / 1000;
    // ==========================================================
    // Sequence steps and data line enable masks
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_FAST = 2'h2;
    localparam logic [1:0] STEP_DATA = 2'h3;
    localparam logic [15:0] DQ_ALL = 16'hFFFF;
    localparam logic [15:0] DQ_BYTE_WR = 16'h80FF;
    localparam logic [15:0] DQ_BYTE_RD = 16'h8000;
    localparam logic [15:0] DQ_NONE = 16'h0000;
    // ==========================================================
    // User operations
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_PROGRAM, OP_CLEAR} op_e;
endpackage : flash_host_pkg
`default_nettype wire

// ### tb/flash_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
    // Arbitrary identification value
    parameter logic [15:0] ID_CODE = 16'h5A3C
) (
    // Strobes
    input wire logic clk,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic resetN,
    input wire logic byteN,
    input wire logic protAccel,
    input wire logic highVolt,
    input wire logic bypass,
    // Address and data
    input wire logic [21:0] addr,
    input wire logic [15:0] hostDq,
    input wire logic [15:0] hostOe,
    output logic [15:0] dq,
    output logic busyN
);
    // ====
    // Decode
    logic [7:0] mem [0:127];
    logic [15:0] lastDq;
    logic [15:0] devDq;
    logic [5:0] wi;
    logic [6:0] bi;
    logic [1:0] unlock;
    logic [1:0] busyBank;
    logic armed;
    logic ready;
    logic suspended;
    logic eraseArm;
    logic idMode;
    logic statusRd;
    logic [2:0] eraseSect;
    int busyCnt;
    assign wi = {addr[21:20], addr[3:0]};
    assign bi = {wi, hostDq[15]};
    assign busyN = (busyCnt == 0) || suspended;
    // Busy bank answers with status, except sectors a suspended erase leaves alone
    assign statusRd = (busyCnt != 0) && (addr[21:20] == busyBank)
        && !(suspended && wi[5:3] != eraseSect);
    // Undriven lines show the inverse of the last value, never a stale match
    always_comb begin
        devDq = ~lastDq;
        if (!ceN && !oeN && resetN && ready) begin
            if (idMode) devDq = ID_CODE;
            else if (!byteN) devDq[7:0] = mem[bi];
            else if (statusRd) devDq = ~{mem[{wi, 1'b1}], mem[{wi, 1'b0}]};
            else devDq = {mem[{wi, 1'b1}], mem[{wi, 1'b0}]};
        end
    end
    assign dq = (hostOe & hostDq) | (~hostOe & devDq);
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
        lastDq = 16'h0000;
        busyCnt = 0;
        unlock = 2'h0;
        armed = 1'b0;
        ready = 1'b0;
        suspended = 1'b0;
        eraseArm = 1'b0;
        idMode = 1'b0;
        eraseSect = 3'h0;
        busyBank = 2'h0;
    end
    // ====
    // Command decoder; program only clears bits, like real cells
    always @(posedge clk) begin
        lastDq <= dq;
        ready <= !ceN && !oeN;
        if (busyCnt != 0 && !suspended) busyCnt <= busyCnt - 1;
        if (!resetN) begin
            unlock <= 2'h0;
            armed <= 1'b0;
            eraseArm <= 1'b0;
            idMode <= 1'b0;
            suspended <= 1'b0;
            if (busyCnt != 0) busyCnt <= 3;
        end else if (!weN && !ceN && oeN) begin
            if (armed) begin
                if (!byteN) mem[bi] <= mem[bi] & hostDq[7:0];
                else begin
                    mem[{wi, 1'b0}] <= mem[{wi, 1'b0}] & hostDq[7:0];
                    mem[{wi, 1'b1}] <= mem[{wi, 1'b1}] & hostDq[15:8];
                end
                armed <= 1'b0;
                unlock <= 2'h0;
                busyCnt <= 20;
                busyBank <= addr[21:20];
            end else if (hostDq[7:0] == 8'hA0
                && (unlock == 2'h2 || bypass || (highVolt && protAccel))) begin
                armed <= 1'b1;
            end else if (busyCnt != 0 && hostDq[7:0] == 8'hB0) begin
                suspended <= 1'b1;
            end else if (suspended && hostDq[7:0] == 8'h30) begin
                suspended <= 1'b0;
            end else if (unlock == 2'h2 && hostDq[7:0] == 8'h90) begin
                idMode <= 1'b1;
                unlock <= 2'h0;
            end else if (unlock == 2'h2 && hostDq[7:0] == 8'h80) begin
                eraseArm <= 1'b1;
                unlock <= 2'h0;
            end else if (eraseArm && unlock == 2'h2
                && (hostDq[7:0] == 8'h30 || hostDq[7:0] == 8'h10)) begin
                // Sector is bank plus top word bit; code 10 clears every sector
                for (int i = 0; i < 128; i++)
                    if (hostDq[7:0] == 8'h10 || 3'(i >> 4) == wi[5:3]) mem[i] <= 8'hFF;
                eraseArm <= 1'b0;
                unlock <= 2'h0;
                busyCnt <= 20;
                busyBank <= addr[21:20];
                eraseSect <= wi[5:3];
            end else if (hostDq[7:0] == 8'hF0) begin
                idMode <= 1'b0;
                eraseArm <= 1'b0;
                unlock <= 2'h0;
            end else begin
                unlock <= (hostDq[7:0] == 8'hAA) ? 2'h1
                    : (unlock == 2'h1 && hostDq[7:0] == 8'h55) ? 2'h2 : 2'h0;
            end
        end
    end
endmodule : flash_dev_model
`default_nettype wire

// ### tb/flash_host_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl_tb;
    import flash_host_pkg::*;
    // Arbitrary identification value
    localparam logic [15:0] ID_WORD = 16'h5A3C;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cmdValid = 1'b0;
    logic byteMode = 1'b0;
    logic fastMode = 1'b0;
    logic accelReq = 1'b0;
    logic [1:0] cmdOp = 2'h0;
    logic [22:0] cmdAddr = 23'h000000;
    logic [15:0] cmdData = 16'h0000;
    logic cmdReady, rdValid, opAborted, deviceBusy, ceN, oeN, weN, resetN, byteN, busyN, prot, hv;
    logic [15:0] rdData, dqOut, dqOe, dq;
    logic [21:0] fAddr;
    logic [7:0] shadow [0:127];
    logic [15:0] expQ [$];
    int errors = 0;
    int n_tests = 0;
    always #50 clk = ~clk;
    flash_host_ctrl flash_host_ctrl_i (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .byteMode(byteMode),
        .fastMode(fastMode), .accelReq(accelReq), .cmdReady(cmdReady), .rdValid(rdValid),
        .rdData(rdData), .opAborted(opAborted), .deviceBusy(deviceBusy), .flashCeN(ceN),
        .flashOeN(oeN), .flashWeN(weN), .flashResetN(resetN), .flashByteN(byteN),
        .flashAddr(fAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dq), .busy_output_n(busyN),
        .protect_accel_pin(prot), .high_program_voltage(hv));
    flash_dev_model #(.ID_CODE(ID_WORD)) flash_dev_model_i (.clk(clk), .ceN(ceN), .oeN(oeN),
        .weN(weN), .resetN(resetN), .byteN(byteN), .protAccel(prot), .highVolt(hv),
        .bypass(fastMode), .addr(fAddr), .hostDq(dqOut), .hostOe(dqOe), .dq(dq), .busyN(busyN));
    // ====
    // Checks and bus tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic checkFlag(input logic got, input logic exp);
        check({15'h0000, got}, {15'h0000, exp});
    endtask : checkFlag
    task automatic summarize();
        errors += expQ.size();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic settle();
        int n;
        n = 0;
        @(negedge clk);
        while (cmdReady !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) errors++;
    endtask : settle
    task automatic issue(input op_e o, input logic [22:0] a, input logic [15:0] d);
        @(posedge clk);
        cmdOp <= o;
        cmdAddr <= a;
        cmdData <= d;
        cmdValid <= 1'b1;
        settle();
        @(posedge clk);
        cmdValid <= 1'b0;
    endtask : issue
    task automatic waitIdle();
        int n;
        n = 0;
        while (deviceBusy !== 1'b0 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) errors++;
    endtask : waitIdle
    task automatic prog(input logic [1:0] b, input logic [3:0] w, input logic lsb,
        input logic [15:0] d);
        issue(OP_PROGRAM, {b, 16'h0000, w, lsb}, d);
        settle();
        if (byteMode) shadow[{b, w, lsb}] &= d[7:0];
        else begin
            shadow[{b, w, 1'b0}] &= d[7:0];
            shadow[{b, w, 1'b1}] &= d[15:8];
        end
    endtask : prog
    task automatic rd(input logic [1:0] b, input logic [3:0] w, input logic lsb);
        if (byteMode) expQ.push_back({8'h00, shadow[{b, w, lsb}]});
        else expQ.push_back({shadow[{b, w, 1'b1}], shadow[{b, w, 1'b0}]});
        issue(OP_READ, {b, 16'h0000, w, lsb}, 16'h0000);
    endtask : rd
    task automatic cmd(input logic [22:0] a, input logic [7:0] c);
        issue(OP_WRITE, a, {8'h00, c});
    endtask : cmd
    // ====
    // Read results, oldest note first
    always @(posedge clk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) errors++;
            else check(rdData, expQ.pop_front());
        end
    end
    initial begin
        #2000000;
        errors++;
        summarize();
    end
    // ====
    // Scenarios
    initial begin
        int seed;
        logic [15:0] d;
        seed = $urandom(32'h6163);
        for (int i = 0; i < 128; i++) shadow[i] = 8'(i * 37 + 5);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(2'h1, 4'h3, 1'b0);
        // Normal, bypass and accelerated program, then a read in another bank
        for (int m = 0; m < 3; m++) begin
            d = 16'($urandom);
            fastMode <= (m == 1);
            accelReq <= (m == 2);
            prog(2'(m), 4'(m + 1), 1'b0, d);
            checkFlag(hv, m == 2);
            checkFlag(deviceBusy, 1'b1);
            rd(2'h3, 4'h7, 1'b0);
            waitIdle();
            rd(2'(m), 4'(m + 1), 1'b0);
        end
        @(posedge clk);
        accelReq <= 1'b0;
        fastMode <= 1'b0;
        byteMode <= 1'b1;
        repeat (2) @(negedge clk);
        checkFlag(hv, 1'b0);
        d = 16'($urandom);
        prog(2'h0, 4'h9, 1'b1, d);
        waitIdle();
        rd(2'h0, 4'h9, 1'b1);
        rd(2'h0, 4'h9, 1'b0);
        @(posedge clk);
        byteMode <= 1'b0;
        @(negedge clk);
        prog(2'h1, 4'hA, 1'b0, d);
        issue(OP_CLEAR, 23'h000000, 16'h0000);
        settle();
        checkFlag(opAborted, 1'b1);
        waitIdle();
        issue(OP_CLEAR, 23'h000000, 16'h0000);
        settle();
        checkFlag(opAborted, 1'b0);
        rd(2'h1, 4'hA, 1'b0);
        // Identification codes, then back to array reads
        cmd(23'h000AAA, 8'hAA);
        cmd(23'h000554, 8'h55);
        cmd(23'h000AAA, 8'h90);
        expQ.push_back(ID_WORD);
        issue(OP_READ, 23'h000000, 16'h0000);
        cmd(23'h000000, 8'hF0);
        rd(2'h0, 4'h9, 1'b0);
        // Sector erase in bank 2, suspended for a read of its other sector
        cmd(23'h000AAA, 8'hAA);
        cmd(23'h000554, 8'h55);
        cmd(23'h000AAA, 8'h80);
        cmd(23'h000AAA, 8'hAA);
        cmd(23'h000554, 8'h55);
        cmd({2'h2, 16'h0000, 4'h3, 1'b0}, 8'h30);
        settle();
        checkFlag(deviceBusy, 1'b1);
        cmd(23'h000000, 8'hB0);
        settle();
        checkFlag(deviceBusy, 1'b0);
        rd(2'h2, 4'h8, 1'b0);
        cmd(23'h000000, 8'h30);
        settle();
        waitIdle();
        for (int k = 0; k < 16; k++) shadow[{2'h2, 1'b0, 4'(k)}] = 8'hFF;
        rd(2'h2, 4'h5, 1'b0);
        rd(2'h2, 4'h8, 1'b1);
        repeat (10) @(posedge clk);
        summarize();
    end
endmodule : flash_host_ctrl_tb
`default_nettype wire
